// ---- acs_pkg.sv ----
// Purpose: shared constants and types of the conversion sequencer
// Assumes: 8-bit converter, registers on a 32-bit apb bus
// Notes:   conversion counts are in system clock cycles
package acs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  CTL_ONE_OFS = 8'h00;
  localparam logic [7:0]  CTL_TWO_OFS = 8'h04;
  localparam logic [7:0]  RES_VAL_OFS = 8'h08;
  localparam logic [7:0]  RES_FLG_OFS = 8'h0c;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int          CHAN_LSB    = 0;
  localparam int          CHAN_W      = 4;
  localparam int          DISABLE_BIT = 4;
  localparam int          START_BIT   = 7;
  localparam int          TIME_LSB    = 1;
  localparam int          TIME_W      = 3;
  localparam int          REF_BIT     = 5;
  localparam int          BUSY_BIT    = 4;
  localparam int          DONE_BIT    = 5;
  localparam logic [6:0]  CTL_ONE_RST = 7'h10;
  localparam logic [5:0]  CTL_TWO_RST = 6'h00;
  localparam logic [7:0]  RESULT_RST  = 8'h00;

  // ****************************************
  // conversion durations, in fc cycles
  // ****************************************
  localparam int          CNT_W       = 11;
  localparam logic [10:0] CYC_39      = 11'd39;
  localparam logic [10:0] CYC_78      = 11'd78;
  localparam logic [10:0] CYC_156     = 11'd156;
  localparam logic [10:0] CYC_312     = 11'd312;
  localparam logic [10:0] CYC_624     = 11'd624;
  localparam logic [10:0] CYC_1248    = 11'd1248;

  // reserved codes fall back to the middle setting
  function automatic logic [10:0] conv_cycles(input logic [2:0] sel);
    case (sel)
      3'h0:    conv_cycles = CYC_39;
      3'h2:    conv_cycles = CYC_78;
      3'h3:    conv_cycles = CYC_156;
      3'h4:    conv_cycles = CYC_312;
      3'h5:    conv_cycles = CYC_624;
      3'h6:    conv_cycles = CYC_1248;
      default: conv_cycles = CYC_312;
    endcase
  endfunction

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_conv = 2'b01
  } acs_state_type;

  typedef struct packed {
    logic [3:0] channel;
    logic       input_disable;
    logic       ref_on;
    logic       sampling;
  } acs_analog_ctl_type;

endpackage

// ---- acs_conv_timer.sv ----
// Purpose: down counter that times one conversion
// Assumes: load is a single-cycle strobe, abort may stay high for many cycles, both on pclk
// Notes:   expire pulses in the last cycle of the count
`timescale 1ns/1ps
module acs_conv_timer #(
  parameter int W = 11
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_count,
  input  wire logic         abort,
  // status
  output logic              running,
  output logic              expire
);

  logic [W-1:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (load) begin
      count <= load_count;
    end else if (abort) begin
      count <= '0;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  assign running = (count != '0);
  assign expire  = (count == W'(1)) && !abort;

endmodule

// ---- acs_sequencer.sv ----
// Purpose: apb-controlled sequencer around an 8-bit sar converter
// Assumes: low_power_mode comes from the clock controller on pclk
// Notes:   analog_code comes from the analog core and is resynchronised
//
// Notes on behaviour
// - channel select field of control one routes that input to the converter
// - input disable field of control one is passed to the analog pins
// - time field of control two picks conversion length in clock cycles
// - writing 1 to bit 7 of control one starts a conversion
// - at time-out store result, set done flag, pulse interrupt together
// - reading the result clears the done flag
// - new start clears done but old result stays until completion
// - result is an unsigned 8-bit value
// - stop or slow mode aborts and resets both control registers
// - stop or slow mode discards earlier results
// - no automatic restart after leaving stop or slow mode
// - reference disconnected while in stop or slow mode
// - start bit clears itself once the conversion begins
// - busy flag set at start, cleared at completion or low power
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module acs_sequencer (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [acs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // power mode
  input  wire logic                      low_power_mode,
  // analog core
  input  wire logic [7:0]                analog_code,
  output acs_pkg::acs_analog_ctl_type    analog_ctl,
  // event
  output logic                           conv_done_irq
);

  // ****************************************
  // state
  // ****************************************
  acs_pkg::acs_state_type state;
  logic [6:0]             ctl_one;
  logic [5:0]             ctl_two;
  logic                   conv_start_bit;
  logic [7:0]             conv_result_value;
  logic                   conv_done_flag;
  logic [7:0]             code_meta;
  logic [7:0]             code_sync;
  logic                   timer_running;
  logic                   timer_expire;
  logic                   begin_conv;
  logic                   finish_conv;
  logic                   conv_busy_flag;

  // ****************************************
  // bus decode
  // ****************************************
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic rd_access;
  logic addr_hit;
  logic sel_one;
  logic sel_two;
  logic sel_val;
  logic sel_flg;

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access    = access_phase && pwrite;
  assign rd_access    = access_phase && !pwrite;

  assign sel_one  = (paddr == acs_pkg::CTL_ONE_OFS);
  assign sel_two  = (paddr == acs_pkg::CTL_TWO_OFS);
  assign sel_val  = (paddr == acs_pkg::RES_VAL_OFS);
  assign sel_flg  = (paddr == acs_pkg::RES_FLG_OFS);
  assign addr_hit = sel_one || sel_two || sel_val || sel_flg;

  // every access finishes in its first access cycle
  assign pready  = access_phase;
  assign pslverr = access_phase && !addr_hit;

  assign conv_busy_flag = (state == acs_pkg::st_conv);
  assign begin_conv     = conv_start_bit && !conv_busy_flag && !low_power_mode;
  assign finish_conv    = conv_busy_flag && timer_expire && !low_power_mode;

  // ****************************************
  // read data
  // ****************************************
  // captured in the setup cycle so prdata is a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (sel_one) begin
        prdata[6:0]                  <= ctl_one;
        prdata[acs_pkg::START_BIT]   <= conv_start_bit;
      end else if (sel_two) begin
        prdata[5:0]                  <= ctl_two;
      end else if (sel_val) begin
        prdata[7:0]                  <= conv_result_value;
      end else if (sel_flg) begin
        prdata[acs_pkg::DONE_BIT]    <= conv_done_flag;
        prdata[acs_pkg::BUSY_BIT]    <= conv_busy_flag;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_one <= acs_pkg::CTL_ONE_RST;
      ctl_two <= acs_pkg::CTL_TWO_RST;
    end else if (low_power_mode) begin
      ctl_one <= acs_pkg::CTL_ONE_RST;
      ctl_two <= acs_pkg::CTL_TWO_RST;
    end else if (wr_access) begin
      if (sel_one) begin
        ctl_one <= pwdata[6:0];
      end
      if (sel_two) begin
        ctl_two <= pwdata[5:0];
      end
    end
  end

  // ****************************************
  // start bit
  // ****************************************
  // a start written while busy or still pending is dropped, never restarts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start_bit <= 1'b0;
    end else if (low_power_mode) begin
      conv_start_bit <= 1'b0;
    end else if (wr_access && sel_one && pwdata[acs_pkg::START_BIT]) begin
      conv_start_bit <= !(conv_busy_flag || conv_start_bit);
    end else if (conv_start_bit) begin
      conv_start_bit <= 1'b0;
    end
  end

  // ****************************************
  // conversion sequence
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= acs_pkg::st_idle;
    end else begin
      case (state)
        acs_pkg::st_idle: begin
          if (begin_conv) begin
            state <= acs_pkg::st_conv;
          end
        end
        acs_pkg::st_conv: begin
          // busy ends on finish or abort
          if (low_power_mode || finish_conv) begin
            state <= acs_pkg::st_idle;
          end
        end
        default: begin
          state <= acs_pkg::st_idle;
        end
      endcase
    end
  end

  acs_conv_timer #(
    .W          (acs_pkg::CNT_W)
  ) u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (begin_conv),
    .load_count (acs_pkg::conv_cycles(ctl_two[acs_pkg::TIME_LSB +: acs_pkg::TIME_W])),
    .abort      (low_power_mode),
    .running    (timer_running),
    .expire     (timer_expire)
  );

  // ****************************************
  // analog code resynchroniser
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_meta <= 8'h00;
      code_sync <= 8'h00;
    end else begin
      code_meta <= analog_code;
      code_sync <= code_meta;
    end
  end

  // ****************************************
  // result and done flag
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_result_value <= acs_pkg::RESULT_RST;
    end else if (low_power_mode) begin
      conv_result_value <= acs_pkg::RESULT_RST;
    end else if (finish_conv) begin
      conv_result_value <= code_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_flag <= 1'b0;
    end else if (low_power_mode) begin
      conv_done_flag <= 1'b0;
    end else if (finish_conv) begin
      // set wins over a same-cycle read
      conv_done_flag <= 1'b1;
    end else if (rd_access && sel_val) begin
      conv_done_flag <= 1'b0;
    end else if (begin_conv) begin
      conv_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_irq <= 1'b0;
    end else begin
      conv_done_irq <= finish_conv;
    end
  end

  // ****************************************
  // analog side controls
  // ****************************************
  always_comb begin
    analog_ctl.channel       = ctl_one[acs_pkg::CHAN_LSB +: acs_pkg::CHAN_W];
    analog_ctl.input_disable = ctl_one[acs_pkg::DISABLE_BIT];
    analog_ctl.ref_on        = ctl_two[acs_pkg::REF_BIT] && !low_power_mode;
    analog_ctl.sampling      = conv_busy_flag && timer_running;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [10:0] elapsed;
  logic [10:0] want_cycles;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed     <= 11'd0;
      want_cycles <= 11'd0;
    end else if (begin_conv) begin
      elapsed     <= 11'd1;
      want_cycles <= acs_pkg::conv_cycles(ctl_two[acs_pkg::TIME_LSB +: acs_pkg::TIME_W]);
    end else if (conv_busy_flag) begin
      elapsed     <= elapsed + 11'd1;
    end
  end

  a_conv_length: assert property (
    finish_conv |-> elapsed == want_cycles)
    else $error("conversion length differs from time field");

  a_start_self_clear: assert property (
    begin_conv |=> !conv_start_bit && conv_busy_flag)
    else $error("start bit not cleared at conversion start");

  a_done_with_irq: assert property (
    finish_conv |=> conv_done_flag && conv_done_irq && conv_result_value == $past(code_sync))
    else $error("completion did not store result and raise done and irq");

  a_read_clears_done: assert property (
    rd_access && sel_val && !finish_conv |=> !conv_done_flag)
    else $error("result read left done flag set");

  a_result_held: assert property (
    conv_busy_flag && !finish_conv && !low_power_mode |=> $stable(conv_result_value))
    else $error("result changed before conversion finished");

  a_low_power_reset: assert property (
    low_power_mode |=> !conv_busy_flag && ctl_one == acs_pkg::CTL_ONE_RST
      && ctl_two == acs_pkg::CTL_TWO_RST)
    else $error("low power did not abort and reset controls");

  a_low_power_discard: assert property (
    low_power_mode |=> conv_result_value == acs_pkg::RESULT_RST && !conv_done_flag)
    else $error("low power kept an old result");

  a_no_auto_restart: assert property (
    $fell(low_power_mode) |-> !conv_busy_flag ##1 !conv_busy_flag)
    else $error("conversion restarted without software");

  a_ref_disconnect: assert property (
    low_power_mode |-> !analog_ctl.ref_on)
    else $error("reference on during low power");

  a_busy_span: assert property (
    begin_conv ##1 (conv_busy_flag && !low_power_mode) [*2] |-> !finish_conv || want_cycles <= 11'd3)
    else $error("busy flag ended early");

  a_start_begins: assert property (
    conv_start_bit && !low_power_mode |=> conv_busy_flag)
    else $error("start bit did not begin a conversion");

  a_irq_single: assert property (
    conv_done_irq |=> !conv_done_irq)
    else $error("interrupt longer than one cycle");

  a_start_clears_done: assert property (
    begin_conv |=> !conv_done_flag)
    else $error("new start left done flag set");

  a_finish_ends_busy: assert property (
    finish_conv |=> !conv_busy_flag)
    else $error("busy flag still set after completion");

endmodule

// ---- acs_analog_model.sv ----
// Purpose: behavioural analog core and input pins beside the sequencer
// Assumes: a code is only meaningful while sampling is high
// Notes:   outside sampling the code toggles, so a stale capture never matches
`timescale 1ns/1ps
module acs_analog_model (
  // clock
  input  wire logic                        pclk,
  // control from the sequencer
  input  wire acs_pkg::acs_analog_ctl_type analog_ctl,
  // converted code
  output logic [7:0]                       analog_code
);
  // selected pin, disabled pins, reference off
  always @(posedge pclk) begin
    if (analog_ctl.sampling) begin
      if (analog_ctl.ref_on && !analog_ctl.input_disable) begin
        analog_code <= {analog_ctl.channel, ~analog_ctl.channel};
      end else begin
        analog_code <= 8'h00;
      end
    end else begin
      analog_code <= ~analog_code;
    end
  end

  initial analog_code = 8'h00;
endmodule

// ---- adc_conversion_sequencer_tb.sv ----
// Purpose: self-checking bench of the conversion sequencer
// Assumes: zero-wait apb slave, start takes one edge, irq one cycle late
// Notes:   one idle cycle between apb transfers keeps drivers race free
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        low_power_mode, conv_done_irq;
  logic [7:0]  paddr, analog_code;
  logic [31:0] pwdata, prdata, rd;
  logic        err;
  int          num_errors, n_checks, cnt;
  acs_pkg::acs_analog_ctl_type analog_ctl;

  acs_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power_mode(low_power_mode), .analog_code(analog_code),
    .analog_ctl(analog_ctl), .conv_done_irq(conv_done_irq));
  acs_analog_model core (.pclk(pclk), .analog_ctl(analog_ctl), .analog_code(analog_code));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: the watchdog ends a slave that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  // edges from the write edge until the irq is seen
  task automatic wait_irq();
    cnt = 0;
    do begin
      @(posedge pclk);
      #1;
      cnt++;
    end while (conv_done_irq !== 1'b1 && cnt < 2000);
  endtask

  function automatic int exp_cycles(input int sel);
    case (sel)
      0: return 39;
      2: return 78;
      3: return 156;
      5: return 624;
      6: return 1248;
      default: return 312;
    endcase
  endfunction

  task automatic t_reset();
    rd_chk("ctl_one", 8'h00, 32'h10);
    rd_chk("ctl_two", 8'h04, 32'h00);
    rd_chk("result", 8'h08, 32'h00);
    rd_chk("flags", 8'h0c, 32'h00);
  endtask

  // every time code, reserved ones included
  task automatic t_timing();
    for (int sel = 0; sel < 8; sel++) begin
      apb(1'b1, 8'h04, 32'h30 | (sel << 1));
      apb(1'b1, 8'h00, 32'ha0 | sel);
      wait_irq();
      check("cycles", cnt, exp_cycles(sel) + 1);
      check("channel", {28'h0, analog_ctl.channel}, sel);
      @(posedge pclk);
      #1;
      check("irq pulse", {31'h0, conv_done_irq}, 32'h0);
      rd_chk("flags done", 8'h0c, 32'h20);
      rd_chk("result", 8'h08, {24'h0, sel[3:0], ~sel[3:0]});
      rd_chk("flags read", 8'h0c, 32'h00);
    end
  endtask

  // disabled input reaches the converter as zero
  task automatic t_disabled();
    apb(1'b1, 8'h04, 32'h30);
    apb(1'b1, 8'h00, 32'hb3);
    wait_irq();
    check("dis cycles", cnt, 32'd40);
    rd_chk("dis result", 8'h08, 32'h00);
  endtask

  task automatic t_restart();
    apb(1'b1, 8'h04, 32'h30);
    apb(1'b1, 8'h00, 32'ha2);
    wait_irq();
    apb(1'b1, 8'h00, 32'ha6);
    rd_chk("start clear", 8'h00, 32'h26);
    rd_chk("flags busy", 8'h0c, 32'h10);
    rd_chk("old result", 8'h08, 32'h2d);
    wait_irq();
    check("second irq", {31'h0, conv_done_irq}, 32'h1);
    rd_chk("new result", 8'h08, 32'h69);
  endtask

  task automatic t_low_power();
    apb(1'b1, 8'h00, 32'h31);
    #1;
    check("disable", {31'h0, analog_ctl.input_disable}, 32'h1);
    apb(1'b1, 8'h04, 32'h3c);
    apb(1'b1, 8'h00, 32'ha1);
    repeat (10) @(posedge pclk);
    check("sampling", {31'h0, analog_ctl.sampling}, 32'h1);
    low_power_mode <= 1'b1;
    apb(1'b1, 8'h04, 32'h38);
    #1;
    check("ref off", {31'h0, analog_ctl.ref_on}, 32'h0);
    check("sampling lp", {31'h0, analog_ctl.sampling}, 32'h0);
    @(posedge pclk);
    low_power_mode <= 1'b0;
    rd_chk("ctl_one lp", 8'h00, 32'h10);
    rd_chk("ctl_two lp", 8'h04, 32'h00);
    rd_chk("flags lp", 8'h0c, 32'h00);
    rd_chk("result lp", 8'h08, 32'h00);
    cnt = 0;
    repeat (1300) begin
      @(posedge pclk);
      #1;
      if (conv_done_irq === 1'b1) cnt++;
    end
    check("no restart", cnt, 0);
  endtask

  task automatic t_unmapped();
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped rd", rd, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, 8'h14, 32'hff);
    check("unmapped wr", {31'h0, err}, 32'h1);
    rd_chk("ctl_one kept", 8'h00, 32'h10);
  endtask

  initial begin
    num_errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    low_power_mode = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_timing();
    t_disabled();
    t_restart();
    t_low_power();
    t_unmapped();
    end_of_test();
  end

  // runs about 4700 cycles; a hang ends at 20000 cycles, well after this
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_of_test();
  end
endmodule
